// ===== sas_phy_stats.sv
`timescale 1ns/1ps
module sas_phy_stats
  import sas_phy_stats_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // axi4-lite write address
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // axi4-lite write data
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read address
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // phy receiver and reset events
  input  wire phy_evt_s    EVT,
  input  wire link_s       LINK,
  // identification frames
  input  wire iaf_rx_s     IAF_RX,
  input  wire iaf_tx_s     IAF_TX,
  input  wire logic        SATA_D2H,
  // phy attributes
  input  wire logic        VIRTUAL_PHY,
  input  wire logic        CFG_CHANGE,
  output logic             PHY_EN
);

  typedef struct packed {
    bus_st_e     wst;
    bus_st_e     rst;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        phy_en;
    logic [6:0]  desc_idx;
    logic [3:0]  rate;
    logic [3:0]  own_rsn;
    logic [3:0]  att_rsn;
    logic [2:0]  att_type;
    logic [2:0]  att_init;
    logic [2:0]  att_tgt;
    logic [7:0]  att_phyid;
    logic [63:0] own_addr;
    logic [63:0] att_addr;
  } st_s;

  st_s st_q;
  st_s st_d;

  logic [3:0]        cnt_inc;
  logic [3:0][31:0]  cnt;
  logic [7:0]        gen;
  logic              gen_bump;
  logic              wr_go;
  logic [7:0]        wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic [31:0]       rd_data;
  logic              rd_ok;
  logic [3:0]        rate_rd;
  logic [3:0]        arsn_rd;

  // event qualification feeding the four counters
  always_comb
  begin
    cnt_inc[0] = EVT.invalid_dword && !EVT.in_reset_seq;
    cnt_inc[1] = EVT.disparity_err && EVT.dword_sync;
    cnt_inc[2] = EVT.sync_loss_restart;
    cnt_inc[3] = EVT.reset_problem;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_cnt
      sas_sat_ctr u_cnt (
        .clk   (CLK),
        .rst   (RST),
        .inc   (cnt_inc[gi]),
        .count (cnt[gi])
      );
    end
  endgenerate

  sas_gen_ctr u_gen (
    .clk  (CLK),
    .rst  (RST),
    .bump (gen_bump),
    .gen  (gen)
  );

  // one byte of the event descriptor list, by byte position
  function automatic logic [7:0] desc_byte(
    input logic [6:0]       idx,
    input logic [3:0][31:0] c
  );
    logic [6:0] rel;
    logic [6:0] base;
    logic [7:0] b;
    b = 8'h00;
    rel = idx - DESC_CNT_BASE;
    if (idx >= DESC_CNT_BASE && rel[6:4] == 3'b000)
      b = c[rel[3:2]][{~rel[1:0], 3'b000} +: 8];
    else if (idx == DESC_LEN_POS)
      b = DESC_LEN;
    else if (idx == DESC_NUM_POS)
      b = DESC_NUM;
    for (int k = 0; k < 4; k++)
    begin
      base = DESC_EVT_BASE + DESC_EVT_STRIDE * 7'(k);
      rel = idx - base;
      if (idx >= base && rel == EVT_SRC_OFF)
        b = 8'(k + 1);
      else if (idx >= base && rel[6:2] == EVT_VAL_OFF[6:2])
        b = c[k][{~rel[1:0], 3'b000} +: 8];
      else if (idx >= base && rel[6:2] == EVT_THR_OFF[6:2])
        b = PVD_THRESH[{~rel[1:0], 3'b000} +: 8];
    end
    return b;
  endfunction : desc_byte

  // read decode
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    rate_rd = st_q.phy_en ? st_q.rate : RATE_NONE;
    arsn_rd = VIRTUAL_PHY ? 4'h0 : st_q.att_rsn;
    if (S_AXI_ARADDR == OFF_CTRL)
      rd_data[CTRL_EN_BIT] = st_q.phy_en;
    else if (S_AXI_ARADDR == OFF_DESC_IDX)
      rd_data[6:0] = st_q.desc_idx;
    else if (S_AXI_ARADDR == OFF_DESC_BYTE)
      rd_data[7:0] = desc_byte(st_q.desc_idx, cnt);
    else if (S_AXI_ARADDR == OFF_INV_DWORD)
      rd_data = cnt[0];
    else if (S_AXI_ARADDR == OFF_DISPARITY)
      rd_data = cnt[1];
    else if (S_AXI_ARADDR == OFF_SYNC_LOSS)
      rd_data = cnt[2];
    else if (S_AXI_ARADDR == OFF_RST_PROB)
      rd_data = cnt[3];
    else if (S_AXI_ARADDR == OFF_LINK)
    begin
      rd_data[LINK_RATE_LSB +: 4] = rate_rd;
      rd_data[LINK_GEN_LSB +: 8]  = gen;
      rd_data[LINK_RSN_LSB +: 4]  = st_q.own_rsn;
      rd_data[LINK_ARSN_LSB +: 4] = arsn_rd;
    end
    else if (S_AXI_ARADDR == OFF_ATT_ID)
    begin
      rd_data[ATT_TYPE_LSB +: 3]  = st_q.att_type;
      rd_data[ATT_INIT_LSB +: 3]  = st_q.att_init;
      rd_data[ATT_TGT_LSB +: 3]   = st_q.att_tgt;
      rd_data[ATT_PHYID_LSB +: 8] = st_q.att_phyid;
    end
    else if (S_AXI_ARADDR == OFF_OWN_HI)
      rd_data = st_q.own_addr[63:32];
    else if (S_AXI_ARADDR == OFF_OWN_LO)
      rd_data = st_q.own_addr[31:0];
    else if (S_AXI_ARADDR == OFF_ATT_HI)
      rd_data = st_q.att_addr[63:32];
    else if (S_AXI_ARADDR == OFF_ATT_LO)
      rd_data = st_q.att_addr[31:0];
    else
      rd_ok = 1'b0;
  end

  // handshake outputs
  always_comb
  begin
    S_AXI_AWREADY = (st_q.wst == BUS_IDLE) && !st_q.aw_got;
    S_AXI_WREADY  = (st_q.wst == BUS_IDLE) && !st_q.w_got;
    S_AXI_BVALID  = (st_q.wst == BUS_RESP);
    S_AXI_ARREADY = (st_q.rst == BUS_IDLE);
    S_AXI_RVALID  = (st_q.rst == BUS_RESP);
    S_AXI_BRESP   = st_q.bresp;
    S_AXI_RDATA   = st_q.rdata;
    S_AXI_RRESP   = st_q.rresp;
    PHY_EN        = st_q.phy_en;
  end

  // address and data may arrive in either order
  always_comb
  begin
    wr_addr = st_q.aw_got ? st_q.awaddr : S_AXI_AWADDR;
    wr_data = st_q.w_got ? st_q.wdata : S_AXI_WDATA;
    wr_strb = st_q.w_got ? st_q.wstrb : S_AXI_WSTRB;
    wr_go = (st_q.wst == BUS_IDLE)
          && (st_q.aw_got || S_AXI_AWVALID)
          && (st_q.w_got || S_AXI_WVALID);
  end

  always_comb
  begin
    st_d = st_q;
    gen_bump = CFG_CHANGE;

    // write channel
    case (st_q.wst)
      BUS_IDLE:
      begin
        if (S_AXI_AWVALID && !st_q.aw_got)
        begin
          st_d.aw_got = 1'b1;
          st_d.awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !st_q.w_got)
        begin
          st_d.w_got = 1'b1;
          st_d.wdata = S_AXI_WDATA;
          st_d.wstrb = S_AXI_WSTRB;
        end
        if (wr_go)
        begin
          st_d.aw_got = 1'b0;
          st_d.w_got = 1'b0;
          st_d.wst = BUS_RESP;
          st_d.bresp = RESP_OKAY;
          // read-only words take the write silently
          if (wr_addr[1:0] != 2'b00 || wr_addr > OFF_LAST)
          begin
            st_d.bresp = RESP_SLVERR;
          end
          else if (wr_addr == OFF_CTRL)
          begin
            if (wr_strb[0])
            begin
              st_d.phy_en = wr_data[CTRL_EN_BIT];
              if (wr_data[CTRL_EN_BIT] != st_q.phy_en)
              begin
                gen_bump = 1'b1;
              end
            end
          end
          else if (wr_addr == OFF_DESC_IDX)
          begin
            if (wr_strb[0])
            begin
              st_d.desc_idx = wr_data[6:0];
            end
          end
        end
      end
      BUS_RESP:
      begin
        if (S_AXI_BREADY)
          st_d.wst = BUS_IDLE;
      end
      default: st_d.wst = BUS_IDLE;
    endcase

    // read channel, answer registered one cycle after the address
    case (st_q.rst)
      BUS_IDLE:
      begin
        if (S_AXI_ARVALID)
        begin
          st_d.rst = BUS_RESP;
          st_d.rdata = rd_data;
          st_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
      end
      BUS_RESP:
      begin
        if (S_AXI_RREADY)
          st_d.rst = BUS_IDLE;
      end
      default: st_d.rst = BUS_IDLE;
    endcase

    // link rate from the latest reset sequence
    if (LINK.rate_done)
    begin
      case (LINK.spd)
        SPD_1G5: st_d.rate = RATE_1G5;
        SPD_3G0: st_d.rate = RATE_3G0;
        SPD_6G0: st_d.rate = RATE_6G0;
        default: st_d.rate = RATE_12G;
      endcase
    end

    // incoming identification frame
    if (IAF_RX.valid)
    begin
      st_d.att_rsn = IAF_RX.reason;
      st_d.att_type = IAF_RX.dev_type;
      st_d.att_init = IAF_RX.init_bits;
      st_d.att_tgt = IAF_RX.tgt_bits;
      st_d.att_addr = IAF_RX.sas_addr;
      st_d.att_phyid = IAF_RX.phy_id;
    end
    // a sata device sends no frame carrying a reason
    if (SATA_D2H)
    begin
      st_d.att_rsn = 4'h0;
    end

    // outgoing identification frame
    if (IAF_TX.valid)
    begin
      st_d.own_rsn = IAF_TX.reason;
      st_d.own_addr = IAF_TX.sas_addr;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      // captures, addresses and ids all clear with the rest
      st_q <= '{wst: BUS_IDLE, rst: BUS_IDLE, bresp: RESP_OKAY,
                rresp: RESP_OKAY, phy_en: PHY_EN_RST,
                desc_idx: DESC_IDX_RST, rate: RATE_NONE, default: '0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule : sas_phy_stats

// ===== sas_phy_stats_pkg.sv
package sas_phy_stats_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_DESC_IDX  = 8'h04;
  localparam logic [7:0] OFF_DESC_BYTE = 8'h08;
  localparam logic [7:0] OFF_INV_DWORD = 8'h0c;
  localparam logic [7:0] OFF_DISPARITY = 8'h10;
  localparam logic [7:0] OFF_SYNC_LOSS = 8'h14;
  localparam logic [7:0] OFF_RST_PROB  = 8'h18;
  localparam logic [7:0] OFF_LINK      = 8'h1c;
  localparam logic [7:0] OFF_ATT_ID    = 8'h20;
  localparam logic [7:0] OFF_OWN_HI    = 8'h24;
  localparam logic [7:0] OFF_OWN_LO    = 8'h28;
  localparam logic [7:0] OFF_ATT_HI    = 8'h2c;
  localparam logic [7:0] OFF_ATT_LO    = 8'h30;
  localparam logic [7:0] OFF_LAST      = OFF_ATT_LO;

  // field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int LINK_RATE_LSB  = 0;
  localparam int LINK_GEN_LSB   = 8;
  localparam int LINK_RSN_LSB   = 16;
  localparam int LINK_ARSN_LSB  = 20;
  localparam int ATT_TYPE_LSB   = 0;
  localparam int ATT_INIT_LSB   = 4;
  localparam int ATT_TGT_LSB    = 8;
  localparam int ATT_PHYID_LSB  = 16;

  // reset values and counter limits
  localparam logic       PHY_EN_RST   = 1'b1;
  localparam logic [6:0] DESC_IDX_RST = 7'd40;
  localparam logic [31:0] CNT_RST     = 32'h0000_0000;
  localparam logic [31:0] CNT_MAX     = 32'hffff_ffff;
  localparam logic [7:0] GEN_RST      = 8'h00;
  localparam logic [7:0] GEN_MAX      = 8'hff;
  localparam logic [7:0] GEN_WRAP     = 8'h01;

  // descriptor layout, byte positions
  localparam logic [6:0] DESC_CNT_BASE   = 7'd40;
  localparam logic [6:0] DESC_LEN_POS    = 7'd58;
  localparam logic [6:0] DESC_NUM_POS    = 7'd59;
  localparam logic [6:0] DESC_EVT_BASE   = 7'd60;
  localparam logic [6:0] DESC_EVT_STRIDE = 7'd12;
  localparam logic [6:0] EVT_SRC_OFF     = 7'd3;
  localparam logic [6:0] EVT_VAL_OFF     = 7'd4;
  localparam logic [6:0] EVT_THR_OFF     = 7'd8;
  localparam logic [7:0] DESC_LEN        = 8'h0c;
  localparam logic [7:0] DESC_NUM        = 8'h04;
  localparam logic [31:0] PVD_THRESH     = 32'h0000_0000;

  // negotiated rate codes
  localparam logic [3:0] RATE_NONE = 4'h0;
  localparam logic [3:0] RATE_1G5  = 4'h8;
  localparam logic [3:0] RATE_3G0  = 4'h9;
  localparam logic [3:0] RATE_6G0  = 4'ha;
  localparam logic [3:0] RATE_12G  = 4'hb;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_st_e;

  typedef enum logic [1:0] {
    SPD_1G5 = 2'd0,
    SPD_3G0 = 2'd1,
    SPD_6G0 = 2'd2,
    SPD_12G = 2'd3
  } spd_e;

  typedef struct packed {
    logic invalid_dword;
    logic in_reset_seq;
    logic dword_sync;
    logic disparity_err;
    logic sync_loss_restart;
    logic reset_problem;
  } phy_evt_s;

  typedef struct packed {
    logic rate_done;
    spd_e spd;
  } link_s;

  typedef struct packed {
    logic        valid;
    logic [2:0]  dev_type;
    logic [3:0]  reason;
    logic [2:0]  init_bits;
    logic [2:0]  tgt_bits;
    logic [63:0] sas_addr;
    logic [7:0]  phy_id;
  } iaf_rx_s;

  typedef struct packed {
    logic        valid;
    logic [3:0]  reason;
    logic [63:0] sas_addr;
  } iaf_tx_s;

endpackage : sas_phy_stats_pkg

// ===== sas_sat_ctr.sv
`timescale 1ns/1ps
module sas_sat_ctr
  import sas_phy_stats_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // event
  input  wire logic        inc,
  output logic [31:0]      count
);

  typedef struct packed {
    logic [31:0] cnt;
  } st_s;

  st_s st_q;
  st_s st_d;

  always_comb
  begin
    st_d = st_q;
    // holds at the top instead of wrapping to zero
    if (inc && st_q.cnt != CNT_MAX)
    begin
      st_d.cnt = st_q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q.cnt <= CNT_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign count = st_q.cnt;

endmodule : sas_sat_ctr

// ===== sas_gen_ctr.sv
`timescale 1ns/1ps
module sas_gen_ctr
  import sas_phy_stats_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // change strobe
  input  wire logic        bump,
  output logic [7:0]       gen
);

  typedef struct packed {
    logic [7:0] gen;
  } st_s;

  st_s st_q;
  st_s st_d;

  always_comb
  begin
    st_d = st_q;
    if (bump)
    begin
      // zero means unknown, so the wrap skips it
      if (st_q.gen == GEN_MAX)
      begin
        st_d.gen = GEN_WRAP;
      end
      else
      begin
        st_d.gen = st_q.gen + 8'h01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q.gen <= GEN_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign gen = st_q.gen;

endmodule : sas_gen_ctr

// ===== sas_phy_stats_monitor.sv
`timescale 1ns/1ps
module sas_phy_stats_monitor
  import sas_phy_stats_pkg::*;
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // write side
  input wire logic [7:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  // read side
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  // phy
  input wire logic        PHY_EN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // both halves taken at one edge
  sequence wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  wr_answer_a: assert property (wr_take |=> S_AXI_BVALID)
    else $error("write response missing");
  bad_write_a: assert property (wr_take ##0
    (S_AXI_AWADDR[1:0] != 2'b00 || S_AXI_AWADDR > OFF_LAST)
    |=> S_AXI_BRESP == RESP_SLVERR)
    else $error("bad write address not refused");
  rd_answer_a: assert property (rd_take |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer missing");
  bad_read_a: assert property (rd_take ##0 (S_AXI_ARADDR > OFF_LAST)
    |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  rate_off_a: assert property (
    rd_take ##0 (S_AXI_ARADDR == OFF_LINK && !PHY_EN)
    |=> S_AXI_RDATA[3:0] == RATE_NONE)
    else $error("rate shown while phy disabled");
  b_once_a: assert property (S_AXI_BVALID && S_AXI_BREADY
    |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write response not retired");
  b_refuse_a: assert property (S_AXI_BVALID
    |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while response pending");
  reset_state_a: assert property ($fell(RST) |-> PHY_EN &&
    S_AXI_AWREADY && S_AXI_ARREADY && !S_AXI_BVALID && !S_AXI_RVALID)
    else $error("bad state after reset");
endmodule : sas_phy_stats_monitor

bind sas_phy_stats sas_phy_stats_monitor mon_u (
  .CLK(CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .PHY_EN(PHY_EN));

// ===== sas_link_partner.sv
`timescale 1ns/1ps
module sas_link_partner
  import sas_phy_stats_pkg::*;
(
  // clock and reset
  input  wire logic    clk,
  input  wire logic    rst,
  // frame request
  input  wire logic    send,
  input  wire iaf_rx_s frame,
  output iaf_rx_s      rx
);
  // payload flips outside a frame so a stale capture cannot pass
  always_ff @(posedge clk)
  begin
    if (rst)
      rx <= '0;
    else if (send)
      rx <= {1'b1, frame[$bits(iaf_rx_s)-2:0]};
    else
      rx <= {1'b0, ~rx[$bits(iaf_rx_s)-2:0]};
  end
endmodule : sas_link_partner

// ===== sas_phy_error_statistics_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module sas_phy_error_statistics_test
  import sas_phy_stats_pkg::*;
();
  typedef struct packed {logic [7:0] a; logic [6:0] i; logic [31:0] e;} row_s;
  localparam logic [7:0] DB = OFF_DESC_BYTE;
  logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
  logic arvalid = 1'b0, sata_d2h = 1'b0, virt = 1'b0, cfg = 1'b0;
  logic send = 1'b0, awready, wready, bvalid, arready, rvalid, phy_en;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  phy_evt_s evt = 6'b001000;
  link_s link = '0;
  iaf_rx_s rx_frame = '0, iaf_rx;
  iaf_tx_s iaf_tx = '0;
  int err_count = 0, cmp_count = 0;
  row_s rows [21] = '{'{OFF_INV_DWORD, 7'd0, 32'h3},
    '{OFF_DISPARITY, 7'd0, 32'h2}, '{OFF_SYNC_LOSS, 7'd0, 32'h1},
    '{OFF_RST_PROB, 7'd0, 32'h2}, '{DB, 7'd40, 32'h0}, '{DB, 7'd43, 32'h3},
    '{DB, 7'd47, 32'h2}, '{DB, 7'd51, 32'h1}, '{DB, 7'd55, 32'h2},
    '{DB, 7'd58, 32'hc}, '{DB, 7'd59, 32'h4}, '{DB, 7'd63, 32'h1},
    '{DB, 7'd67, 32'h3}, '{DB, 7'd68, 32'h0}, '{DB, 7'd75, 32'h2},
    '{DB, 7'd79, 32'h2}, '{DB, 7'd87, 32'h3}, '{DB, 7'd91, 32'h1},
    '{DB, 7'd99, 32'h4}, '{DB, 7'd103, 32'h2}, '{DB, 7'd107, 32'h0}};

  always #10 clk = ~clk;

  sas_link_partner lp_u (.clk(clk), .rst(rst), .send(send),
    .frame(rx_frame), .rx(iaf_rx));

  sas_phy_stats dut_u (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(1'b1), .EVT(evt), .LINK(link), .IAF_RX(iaf_rx),
    .IAF_TX(iaf_tx), .SATA_D2H(sata_d2h), .VIRTUAL_PHY(virt),
    .CFG_CHANGE(cfg), .PHY_EN(phy_en));

  // ready is combinational, so it is judged at the falling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw))
    begin
      @(negedge clk);
      ta = ta | awready;
      tw = tw | wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    @(negedge clk);
    while (!bvalid) @(negedge clk);
    r = bresp;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(negedge clk);
    while (!arready) @(negedge clk);
    @(posedge clk);
    arvalid <= 1'b0;
    @(negedge clk);
    while (!rvalid) @(negedge clk);
    d = rdata;
    r = rresp;
    @(posedge clk);
  endtask : rd

  task automatic ev(input logic [5:0] e, input int n);
    evt <= e;
    repeat (n) @(posedge clk);
    evt <= 6'b001000;
    @(posedge clk);
  endtask : ev

  task automatic summarize();
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_CTRL); `CHK(d, 32'h1)
    rd(OFF_LINK); `CHK(d, 32'h0)
    rd(OFF_INV_DWORD); `CHK(d, 32'h0)
    ev(6'b101000, 3);
    ev(6'b111000, 2);
    ev(6'b001100, 2);
    ev(6'b000100, 4);
    ev(6'b001010, 1);
    ev(6'b001001, 2);
    wr(OFF_INV_DWORD, 32'h55); `CHK(r, RESP_OKAY)
    foreach (rows[k])
    begin
      if (rows[k].a == DB) wr(OFF_DESC_IDX, {25'h0, rows[k].i});
      rd(rows[k].a); `CHK(d, rows[k].e)
    end
    for (int s = 0; s < 4; s++)
    begin
      link <= {1'b1, spd_e'(s)};
      @(posedge clk);
      link.rate_done <= 1'b0;
      rd(OFF_LINK); `CHK(d[3:0], RATE_1G5 + 4'(s))
    end
    wr(OFF_CTRL, 32'h0);
    `CHK(phy_en, 1'b0)
    rd(OFF_LINK); `CHK(d[15:0], 16'h0100)
    wr(OFF_CTRL, 32'h1);
    rd(OFF_LINK); `CHK(d[15:0], 16'h020b)
    cfg <= 1'b1;
    repeat (253) @(posedge clk);
    cfg <= 1'b0;
    rd(OFF_LINK); `CHK(d[15:8], GEN_MAX)
    cfg <= 1'b1;
    @(posedge clk);
    cfg <= 1'b0;
    rd(OFF_LINK); `CHK(d[15:8], GEN_WRAP)
    rx_frame <= '{1'b1, 3'h2, 4'h5, 3'h6, 3'h3, 64'h5a5a_0000_1234_5678, 8'h07};
    iaf_tx <= '{1'b1, 4'h3, 64'h5a5a_0000_abcd_0001};
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    iaf_tx.valid <= 1'b0;
    // the partner's frame lands one edge later; read after the capture
    @(posedge clk);
    rd(OFF_ATT_ID); `CHK(d, 32'h0007_0362)
    rd(OFF_ATT_HI); `CHK(d, 32'h5a5a_0000)
    rd(OFF_ATT_LO); `CHK(d, 32'h1234_5678)
    rd(OFF_OWN_HI); `CHK(d, 32'h5a5a_0000)
    rd(OFF_OWN_LO); `CHK(d, 32'habcd_0001)
    rd(OFF_LINK); `CHK(d[23:16], 8'h53)
    virt <= 1'b1;
    rd(OFF_LINK); `CHK(d[23:20], 4'h0)
    virt <= 1'b0;
    sata_d2h <= 1'b1;
    @(posedge clk);
    sata_d2h <= 1'b0;
    rd(OFF_LINK); `CHK(d[23:16], 8'h03)
    rd(8'h40); `CHK({r, d}, {RESP_SLVERR, 32'h0})
    wr(8'h05, 32'h0); `CHK(r, RESP_SLVERR)
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_INV_DWORD); `CHK(d, 32'h0)
    rd(OFF_LINK); `CHK(d, 32'h0)
    summarize();
  end

  // the sequence needs a few hundred cycles; this allows twenty thousand
  initial
  begin
    #400000;
    err_count++;
    summarize();
  end
endmodule : sas_phy_error_statistics_test
